/* File: verilog/dsg_pkg.sv */
package dsg_pkg;
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam int IO_ADDR_W   = 8;
    localparam int SEL_LSB     = 2;
    localparam int SEL_W       = 3;
    localparam int NUM_SEL     = 8;
    localparam logic [IO_ADDR_W-1:0] SEL_BASE_DEF = 8'h80;
    localparam logic [IO_ADDR_W-1:SEL_LSB+SEL_W] SEL_PAGE_DEF = 3'h4;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Master ownership
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSG_OWN_CPU  = 2'b00,
        DSG_OWN_DMA  = 2'b01,
        DSG_OWN_NONE = 2'b10
    } dsg_owner_t;
endpackage : dsg_pkg

/* File: verilog/dsg_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dsg_sync #(
    parameter int         WIDTH = 1,
    parameter logic [0:0] RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;

    // ------------------------------------------------------------
    // Accept a change once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        nxt_out = out_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_out[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff  <= {WIDTH{RST_VAL}};
            s2_ff  <= {WIDTH{RST_VAL}};
            s3_ff  <= {WIDTH{RST_VAL}};
            out_ff <= {WIDTH{RST_VAL}};
        end else begin
            s1_ff  <= async_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_out = out_ff;
endmodule // dsg_sync
`default_nettype wire

/* File: verilog/dsg_glue.sv */
`timescale 1ns/1ps
`default_nettype none
module dsg_glue
    import dsg_pkg::*;
#(
    parameter int         N_SEL     = dsg_pkg::NUM_SEL,
    parameter logic [2:0] SEL_PAGE  = dsg_pkg::SEL_PAGE_DEF,
    parameter logic [7:0] READABLE  = 8'hff,
    parameter logic       MULTI     = 1'b0,
    parameter logic       GATE_OPF  = 1'b1,
    parameter logic       MWR_DELAY = 1'b1
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // System bus pins
    input  wire logic [7:0]           addr_lo,
    input  wire logic                 io_request_n,
    input  wire logic                 memory_request_n,
    input  wire logic                 opcode_fetch_n,
    input  wire logic                 read_n,
    input  wire logic                 write_n,
    input  wire logic                 wait_request_n,
    // Bus ownership
    input  wire logic                 bus_grant_n,
    input  wire logic                 grant_chain_in_n,
    input  wire logic                 grant_chain_out_n,
    // Flyby
    input  wire logic                 flyby_en,
    input  wire logic                 dma_read_n,
    // Selects and shared pin
    output logic [7:0]                periph_sel_n,
    output logic                      dma_sel_wait_n,
    // Buffer enables, low enables, and data direction
    output logic                      cpu_buf_oe_n,
    output logic                      dma_buf_oe_n,
    output logic                      data_buf_oe_n,
    output logic                      data_dir_out,
    // Flyby strobes
    output logic                      flyby_mem_write_n,
    output logic                      flyby_io_write_n,
    output logic                      flyby_io_read_n,
    // Status
    output dsg_pkg::dsg_owner_t       bus_owner
);
    import dsg_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NIN = 16;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn;
    assign raw_in = {addr_lo, io_request_n, memory_request_n,
                     opcode_fetch_n, read_n, wait_request_n,
                     bus_grant_n, grant_chain_in_n, dma_read_n};

    dsg_sync #(.WIDTH(NIN), .RST_VAL(1'b1)) u_sync (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .async_in (raw_in),
        .sync_out (syn)
    );

    logic [7:0] s_addr;
    logic s_ioreq_n, s_memory_request_n_n, s_opf_n, s_rd_n, s_wait_n;
    logic s_grant_n, s_gin_n, s_drd_n;
    assign {s_addr, s_ioreq_n, s_memory_request_n_n, s_opf_n, s_rd_n, s_wait_n,
            s_grant_n, s_gin_n, s_drd_n} = syn;

    // Grant-out and write come from the same clocked logic
    logic s_gout_n;
    logic s_wr_n;
    assign s_gout_n = grant_chain_out_n;
    assign s_wr_n   = write_n;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic [7:0]  sel_n_ff, nxt_sel_n;
    logic        sw_ff, nxt_sw;
    logic        cpu_oe_ff, nxt_cpu_oe, dma_oe_ff, nxt_dma_oe;
    logic        dbuf_oe_ff, nxt_dbuf_oe, dir_ff, nxt_dir;
    logic        mwr_ff, nxt_mwr, flyby_io_write_n_ff, nxt_flyby_io_write_n, flyby_io_read_n_ff, nxt_flyby_io_read_n;
    logic        rd_neg_ff, nxt_rd_neg;
    dsg_owner_t  own_ff, nxt_own;
    logic        dma_master, vec_cycle, any_rd_sel;

    always_comb begin
        nxt_sel_n = 8'hff;
        if (!s_ioreq_n &&
            (s_addr[IO_ADDR_W-1:SEL_LSB+SEL_W] == SEL_PAGE) &&
            !(GATE_OPF && !s_opf_n)) begin
            nxt_sel_n[s_addr[SEL_LSB +: SEL_W]] = 1'b0;
        end
        dma_master = MULTI ? (!s_gin_n && s_gout_n)
                           : !s_grant_n;
        nxt_sw  = dma_master ? s_wait_n : nxt_sel_n[0];
        nxt_own = dma_master ? DSG_OWN_DMA : DSG_OWN_CPU;
        nxt_dma_oe = !dma_master;
        nxt_cpu_oe = dma_master;
        any_rd_sel = |(~nxt_sel_n & READABLE);
        vec_cycle  = !s_opf_n && !s_ioreq_n;
        nxt_dir = (any_rd_sel && !s_rd_n)
               || vec_cycle
               || (dma_master && !s_wr_n);
        nxt_dbuf_oe = 1'b0;
        // Flyby strobes track DMA read
        nxt_rd_neg = s_drd_n;
        nxt_flyby_io_read_n = !(flyby_en && dma_master && !s_drd_n);
        nxt_flyby_io_write_n = nxt_flyby_io_read_n;
        nxt_mwr  = MWR_DELAY ? (nxt_flyby_io_read_n | rd_neg_ff)
                             : nxt_flyby_io_read_n;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_n_ff   <= 8'hff;
            sw_ff      <= 1'b1;
            cpu_oe_ff  <= 1'b0;
            dma_oe_ff  <= 1'b1;
            dbuf_oe_ff <= 1'b1;
            dir_ff     <= 1'b0;
            mwr_ff     <= 1'b1;
            flyby_io_write_n_ff    <= 1'b1;
            flyby_io_read_n_ff    <= 1'b1;
            rd_neg_ff  <= 1'b1;
            own_ff     <= DSG_OWN_CPU;
        end else begin
            sel_n_ff   <= nxt_sel_n;
            sw_ff      <= nxt_sw;
            cpu_oe_ff  <= nxt_cpu_oe;
            dma_oe_ff  <= nxt_dma_oe;
            dbuf_oe_ff <= nxt_dbuf_oe;
            dir_ff     <= nxt_dir;
            mwr_ff     <= nxt_mwr;
            flyby_io_write_n_ff    <= nxt_flyby_io_write_n;
            flyby_io_read_n_ff    <= nxt_flyby_io_read_n;
            rd_neg_ff  <= nxt_rd_neg;
            own_ff     <= nxt_own;
        end
    end

    // Unshared outputs are driven at all times
    assign periph_sel_n      = sel_n_ff;
    assign dma_sel_wait_n    = sw_ff;
    assign cpu_buf_oe_n      = cpu_oe_ff;
    assign dma_buf_oe_n      = dma_oe_ff;
    assign data_buf_oe_n     = dbuf_oe_ff;
    assign data_dir_out      = dir_ff;
    assign flyby_mem_write_n = mwr_ff;
    assign flyby_io_write_n  = flyby_io_write_n_ff;
    assign flyby_io_read_n   = flyby_io_read_n_ff;
    assign bus_owner         = own_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    one_master_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !(cpu_buf_oe_n == 1'b0 && dma_buf_oe_n == 1'b0))
        else $error("two masters enabled");
    grant_follow_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!MULTI && !s_grant_n) |=> !dma_buf_oe_n)
        else $error("dma buffers not enabled on grant");
    wait_steer_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!MULTI && !s_grant_n) |=> (dma_sel_wait_n == $past(s_wait_n)))
        else $error("wait not steered");
    sel_need_io_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $past(s_ioreq_n) |-> (periph_sel_n == 8'hff))
        else $error("select without io request");
    sel_onehot_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $countones(~periph_sel_n) <= 1)
        else $error("more than one select");
    dir_read_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (any_rd_sel && !s_rd_n) |=> data_dir_out)
        else $error("data buffer not outward on read");
    flyby_pair_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        flyby_io_write_n == flyby_io_read_n)
        else $error("flyby strobes differ");
    flyby_idle_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !$past(flyby_en) |-> flyby_io_read_n)
        else $error("flyby strobe outside flyby");
    mwr_after_rd_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !flyby_mem_write_n |-> !$past(s_drd_n))
        else $error("memory write without dma read");
    chain_master_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (MULTI && !s_gin_n && s_gout_n) |=> (bus_owner == DSG_OWN_DMA))
        else $error("chained dma not taken as master");
endmodule // dsg_glue
`default_nettype wire

/* File: verification/dsg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsg_host_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // DMA side
    input  wire logic bus_request_n,
    input  wire logic slow,
    // Processor and memory side
    output logic      bus_grant_n,
    output logic      wait_request_n
);
    logic [1:0] req_ff;
    logic [1:0] nxt_req;

    always_comb begin
        nxt_req = {req_ff[0], bus_request_n};
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_ff <= 2'h3;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // Grant two cycles after a held request, withdrawn with it
    assign bus_grant_n = req_ff[1] | bus_request_n;
    // Slow memory asks for waits only while the DMA owns the bus
    assign wait_request_n = ~(slow & ~bus_grant_n);
endmodule // dsg_host_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsg_pkg::*;
    logic       mclk, reset_n, io_request_n, memory_request_n;
    logic       opcode_fetch_n, read_n, write_n, wait_request_n;
    logic       bus_grant_n, flyby_en, dma_read_n, bus_request_n, slow;
    logic       chain_in_n, chain_out_n, dma_sel_wait_n, cpu_buf_oe_n;
    logic       dma_buf_oe_n, data_buf_oe_n, data_dir_out;
    logic       flyby_mem_write_n, flyby_io_write_n, flyby_io_read_n;
    logic [7:0] addr_lo, periph_sel_n;
    dsg_owner_t bus_owner;
    logic [7:0] c_sel_n;
    logic       c_sel_wait_n, c_cpu_oe_n, c_dma_oe_n, c_dir;
    logic       c_mwr_n, c_flyby_io_write_n_n, c_flyby_io_read_n_n;
    dsg_owner_t c_owner;
    int         err_total, n_compared;

    dsg_glue dut (.mclk(mclk), .reset_n(reset_n), .addr_lo(addr_lo),
        .io_request_n(io_request_n), .memory_request_n(memory_request_n),
        .opcode_fetch_n(opcode_fetch_n), .read_n(read_n),
        .write_n(write_n), .wait_request_n(wait_request_n),
        .bus_grant_n(bus_grant_n), .grant_chain_in_n(chain_in_n),
        .grant_chain_out_n(chain_out_n), .flyby_en(flyby_en),
        .dma_read_n(dma_read_n), .periph_sel_n(periph_sel_n),
        .dma_sel_wait_n(dma_sel_wait_n), .cpu_buf_oe_n(cpu_buf_oe_n),
        .dma_buf_oe_n(dma_buf_oe_n), .data_buf_oe_n(data_buf_oe_n),
        .data_dir_out(data_dir_out), .flyby_mem_write_n(flyby_mem_write_n),
        .flyby_io_write_n(flyby_io_write_n),
        .flyby_io_read_n(flyby_io_read_n), .bus_owner(bus_owner));

    dsg_host_model host (.mclk(mclk), .reset_n(reset_n),
        .bus_request_n(bus_request_n), .slow(slow),
        .bus_grant_n(bus_grant_n), .wait_request_n(wait_request_n));

    // Chained-master build with GATE_OPF and MWR_DELAY flipped and READABLE set to 8'hfd
    dsg_glue #(.READABLE(8'hfd), .MULTI(1'b1), .GATE_OPF(1'b0),
        .MWR_DELAY(1'b0)) dut_chain (.mclk(mclk), .reset_n(reset_n),
        .addr_lo(addr_lo), .io_request_n(io_request_n),
        .memory_request_n(memory_request_n),
        .opcode_fetch_n(opcode_fetch_n), .read_n(read_n),
        .write_n(write_n), .wait_request_n(wait_request_n),
        .bus_grant_n(bus_grant_n), .grant_chain_in_n(chain_in_n),
        .grant_chain_out_n(chain_out_n), .flyby_en(flyby_en),
        .dma_read_n(dma_read_n), .periph_sel_n(c_sel_n),
        .dma_sel_wait_n(c_sel_wait_n), .cpu_buf_oe_n(c_cpu_oe_n),
        .dma_buf_oe_n(c_dma_oe_n), .data_buf_oe_n(),
        .data_dir_out(c_dir), .flyby_mem_write_n(c_mwr_n),
        .flyby_io_write_n(c_flyby_io_write_n_n), .flyby_io_read_n(c_flyby_io_read_n_n),
        .bus_owner(c_owner));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Synchronised inputs reach the outputs at the fifth edge
    task automatic settle;
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Bounded wait for grant (0), flyby write (1) or chained write (2)
    task automatic wait_low(input int which);
        int   n;
        logic sig;
        n = 0;
        sig = 1'b1;
        while (sig !== 1'b0) begin
            case (which)
                0: sig = bus_grant_n;
                1: sig = flyby_io_write_n;
                default: sig = c_flyby_io_write_n_n;
            endcase
            if (sig !== 1'b0) begin
                if (n == 20) begin
                    err_total++;
                    $display("unexpected timeout: expected 0 seen %b", sig);
                    stop_test();
                end
                n++;
                @(posedge mclk);
                #1;
            end
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("sel", 8'hff, periph_sel_n);
        chk("bufs", 8'h01, {cpu_buf_oe_n, dma_buf_oe_n});
        chk("owner", 8'h00, {6'h0, bus_owner});
        reset_n = 1'b1;
        settle();
        chk("data oe", 8'h00, {7'h0, data_buf_oe_n});
        $display("reset test done");
    endtask

    task automatic t_decode;
        io_request_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            addr_lo = {SEL_PAGE_DEF, i[2:0], 2'h3};
            settle();
            chk("sel", ~(8'h01 << i), periph_sel_n);
            chk("shared", {7'h0, i != 0}, {7'h0, dma_sel_wait_n});
        end
        addr_lo = {3'h5, 5'h04};
        settle();
        chk("sel page", 8'hff, periph_sel_n);
        addr_lo = 8'h84;
        opcode_fetch_n = 1'b0;
        settle();
        chk("sel opf", 8'hff, periph_sel_n);
        opcode_fetch_n = 1'b1;
        io_request_n = 1'b1;
        settle();
        chk("sel idle", 8'hff, periph_sel_n);
        $display("decode test done");
    endtask

    task automatic t_dir;
        io_request_n = 1'b0;
        read_n = 1'b0;
        settle();
        chk("dir read", 8'h01, {7'h0, data_dir_out});
        read_n = 1'b1;
        settle();
        chk("dir in", 8'h00, {7'h0, data_dir_out});
        opcode_fetch_n = 1'b0;
        settle();
        chk("dir vec", 8'h01, {7'h0, data_dir_out});
        opcode_fetch_n = 1'b1;
        io_request_n = 1'b1;
        $display("direction test done");
    endtask

    task automatic t_grant;
        bus_request_n = 1'b0;
        wait_low(0);
        settle();
        chk("bufs dma", 8'h02, {cpu_buf_oe_n, dma_buf_oe_n});
        chk("owner", 8'h01, {6'h0, bus_owner});
        slow = 1'b1;
        settle();
        chk("wait", 8'h00, {7'h0, dma_sel_wait_n});
        slow = 1'b0;
        write_n = 1'b0;
        settle();
        chk("wait off", 8'h01, {7'h0, dma_sel_wait_n});
        chk("dir dmaw", 8'h01, {7'h0, data_dir_out});
        write_n = 1'b1;
        flyby_en = 1'b1;
        dma_read_n = 1'b0;
        wait_low(1);
        chk("mwr lead", 8'h01, {7'h0, flyby_mem_write_n});
        chk("flyby_io_read_n", 8'h00, {7'h0, flyby_io_read_n});
        @(posedge mclk);
        #1;
        chk("mwr", 8'h00, {7'h0, flyby_mem_write_n});
        dma_read_n = 1'b1;
        flyby_en = 1'b0;
        bus_request_n = 1'b1;
        settle();
        chk("fly off", 8'h07, {5'h0, flyby_mem_write_n,
            flyby_io_write_n, flyby_io_read_n});
        chk("bufs cpu", 8'h01, {cpu_buf_oe_n, dma_buf_oe_n});
        $display("grant test done");
    endtask

    task automatic t_chain;
        chain_in_n = 1'b0;
        settle();
        chk("chain owner", 8'h01, {6'h0, c_owner});
        chk("chain bufs", 8'h02, {c_cpu_oe_n, c_dma_oe_n});
        chk("chain wait", 8'h01, {7'h0, c_sel_wait_n});
        flyby_en = 1'b1;
        dma_read_n = 1'b0;
        wait_low(2);
        chk("chain mwr", 8'h00, {7'h0, c_mwr_n});
        chk("chain flyby_io_read_n", 8'h00, {7'h0, c_flyby_io_read_n_n});
        dma_read_n = 1'b1;
        flyby_en = 1'b0;
        chain_out_n = 1'b0;
        settle();
        chk("chain pass", 8'h01, {c_cpu_oe_n, c_dma_oe_n});
        chk("chain fly", 8'h07, {5'h0, c_mwr_n, c_flyby_io_write_n_n, c_flyby_io_read_n_n});
        chain_in_n = 1'b1;
        chain_out_n = 1'b1;
        io_request_n = 1'b0;
        opcode_fetch_n = 1'b0;
        addr_lo = {SEL_PAGE_DEF, 3'h0, 2'h0};
        settle();
        chk("chain opf", 8'hfe, c_sel_n);
        chk("gated opf", 8'hff, periph_sel_n);
        chk("chain shared", 8'h00, {7'h0, c_sel_wait_n});
        opcode_fetch_n = 1'b1;
        addr_lo = {SEL_PAGE_DEF, 3'h1, 2'h0};
        read_n = 1'b0;
        settle();
        chk("dir unreadable", 8'h00, {7'h0, c_dir});
        chk("dir readable", 8'h01, {7'h0, data_dir_out});
        read_n = 1'b1;
        io_request_n = 1'b1;
        $display("chain test done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        {err_total, n_compared} = '0;
        {reset_n, flyby_en, slow} = 3'h0;
        {io_request_n, memory_request_n, opcode_fetch_n, read_n} = 4'hf;
        {write_n, dma_read_n, bus_request_n} = 3'h7;
        {chain_in_n, chain_out_n} = 2'h3;
        addr_lo = 8'h00;
        repeat (3) @(posedge mclk);
        #1;
        t_reset();
        t_decode();
        t_dir();
        t_grant();
        t_chain();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
